// File: sscf_top.sv
`timescale 1ns/10ps
`include "sscf_defs.svh"

// Summary of operation
// - Temperature SAFE, supply dip: hold, slow threshold
// - Pump SAFE, supply dip: hold, fast threshold
// - Supply SAFE, overheat: count up, slow, latch
// - Supply SAFE, pump fault: count up, fast, latch
// - Pump SAFE, overheat: hold count, slow threshold
// - Temperature SAFE, pump fault: hold count
// - Return to ACTIVE restarts refresh timer, unless a counted fault arrives in the same cycle
module sscf_top #(
    parameter int unsigned SLOW_CYCLES = `SSCF_SLOW_CYCLES,
    parameter int unsigned FAST_CYCLES = `SSCF_FAST_CYCLES
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic                 battery_supply_uv,
    input  wire logic                 overtemp,
    input  wire logic                 charge_pump_uv,
    input  wire logic                 safe_enter,
    input  wire sscf_pkg::sscf_cause_t safe_cause,
    input  wire logic [2:0]           entry_fault_count,
    input  wire logic                 return_active,
    output sscf_pkg::sscf_mode_t      mode_q,
    output sscf_pkg::sscf_cause_t     cause_q,
    output logic [2:0]                fault_count_q,
    output logic                      thresh_fast_q,
    output logic                      timer_restart_q,
    output logic                      timer_running_q,
    output logic                      refresh_expired_q
);

    // ----------------------------------------------------------------
    // Fault input synchronisers and rising-edge events
    // ----------------------------------------------------------------
    logic [2:0]  fault_raw;
    logic [2:0]  sync1_q;
    logic [2:0]  sync2_q;
    logic [2:0]  prev_q;
    logic [2:0]  ev;
    logic        ev_batt;
    logic        ev_temp;
    logic        ev_pump;
    logic [31:0] timer_cnt_q;
    logic [31:0] limit;
    logic [2:0]  count_inc;
    logic        in_safe;
    logic        bump;

    assign fault_raw[`SSCF_BIT_BATT] = battery_supply_uv;
    assign fault_raw[`SSCF_BIT_TEMP] = overtemp;
    assign fault_raw[`SSCF_BIT_PUMP] = charge_pump_uv;

    // Detectors run off their own references, so treat them as async
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge core_clk or posedge reset) begin
                if (reset) begin
                    sync1_q[g] <= 1'b0;
                    sync2_q[g] <= 1'b0;
                    prev_q[g]  <= 1'b0;
                end else begin
                    sync1_q[g] <= fault_raw[g];
                    sync2_q[g] <= sync1_q[g];
                    prev_q[g]  <= sync2_q[g];
                end
            end
            assign ev[g] = sync2_q[g] & ~prev_q[g];
        end
    endgenerate

    assign ev_batt = ev[`SSCF_BIT_BATT];
    assign ev_temp = ev[`SSCF_BIT_TEMP];
    assign ev_pump = ev[`SSCF_BIT_PUMP];
    assign in_safe = (mode_q == sscf_pkg::SSCF_SAFE);

    // ----------------------------------------------------------------
    // Decoding of SAFE-state fault events
    // ----------------------------------------------------------------

    // Only a supply-caused SAFE counts a new temperature or pump fault
    function automatic logic count_event(
        input sscf_pkg::sscf_cause_t c,
        input logic [2:0]            e
    );
        count_event = (c == sscf_pkg::SSCF_CAUSE_BATT) &&
                      (e[`SSCF_BIT_TEMP] || e[`SSCF_BIT_PUMP]);
    endfunction

    // Threshold after an event; overheat always forces the slow one
    function automatic logic fast_after(
        input sscf_pkg::sscf_cause_t c,
        input logic [2:0]            e,
        input logic                  cur
    );
        fast_after = cur;
        unique case (c)
            sscf_pkg::SSCF_CAUSE_BATT: begin
                if (e[`SSCF_BIT_TEMP])
                    fast_after = 1'b0;
                else if (e[`SSCF_BIT_PUMP])
                    fast_after = 1'b1;
            end
            sscf_pkg::SSCF_CAUSE_TEMP: begin
                if (e[`SSCF_BIT_BATT] || e[`SSCF_BIT_PUMP])
                    fast_after = 1'b0;
            end
            sscf_pkg::SSCF_CAUSE_PUMP: begin
                if (e[`SSCF_BIT_TEMP])
                    fast_after = 1'b0;
                else if (e[`SSCF_BIT_BATT])
                    fast_after = 1'b1;
            end
            default: fast_after = cur;
        endcase
    endfunction

    assign bump      = in_safe && count_event(cause_q, ev);
    assign count_inc = fault_count_q + 3'h1;

    // ----------------------------------------------------------------
    // Mode and cause
    // ----------------------------------------------------------------

    // Latch is left only by reset, as the part must stay off then
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_q  <= sscf_pkg::SSCF_ACTIVE;
            cause_q <= sscf_pkg::SSCF_CAUSE_BATT;
        end else begin
            unique case (mode_q)
                sscf_pkg::SSCF_ACTIVE: begin
                    if (safe_enter) begin
                        mode_q  <= sscf_pkg::SSCF_SAFE;
                        cause_q <= safe_cause;
                    end
                end
                sscf_pkg::SSCF_SAFE: begin
                    if (bump && count_inc >= `SSCF_LATCH_COUNT)
                        mode_q <= sscf_pkg::SSCF_LATCH;
                    else if (return_active)
                        mode_q <= sscf_pkg::SSCF_ACTIVE;
                end
                sscf_pkg::SSCF_LATCH: begin
                    mode_q <= sscf_pkg::SSCF_LATCH;
                end
                default: mode_q <= sscf_pkg::SSCF_LATCH;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Fault count
    // ----------------------------------------------------------------

    // Entry count comes from the ACTIVE-state logic outside
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fault_count_q <= `SSCF_COUNT_RESET;
        end else if (mode_q == sscf_pkg::SSCF_ACTIVE && safe_enter) begin
            fault_count_q <= entry_fault_count;
        end else if (bump) begin
            fault_count_q <= count_inc;
        end
    end

    // ----------------------------------------------------------------
    // Refresh threshold select
    // ----------------------------------------------------------------

    // Entry threshold follows the cause; supply dip keeps the default
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            thresh_fast_q <= 1'b0;
        end else if (mode_q == sscf_pkg::SSCF_ACTIVE && safe_enter) begin
            thresh_fast_q <= (safe_cause == sscf_pkg::SSCF_CAUSE_PUMP);
        end else if (in_safe) begin
            thresh_fast_q <= fast_after(cause_q, ev, thresh_fast_q);
        end
    end

    // ----------------------------------------------------------------
    // Fault count refresh timer
    // ----------------------------------------------------------------
    assign limit = thresh_fast_q ? FAST_CYCLES : SLOW_CYCLES;

    // Restart from zero on a return to ACTIVE, unless a counted fault (bump) arrives in the same cycle
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            timer_cnt_q       <= 32'h0;
            timer_running_q   <= 1'b0;
            timer_restart_q   <= 1'b0;
            refresh_expired_q <= 1'b0;
        end else begin
            timer_restart_q   <= 1'b0;
            refresh_expired_q <= 1'b0;
            if (in_safe && return_active && !bump) begin
                timer_cnt_q     <= 32'h0;
                timer_running_q <= 1'b1;
                timer_restart_q <= 1'b1;
            end else if (mode_q != sscf_pkg::SSCF_ACTIVE) begin
                timer_running_q <= 1'b0;
            end else if (timer_running_q) begin
                if (timer_cnt_q >= limit - 32'h1) begin
                    timer_running_q   <= 1'b0;
                    refresh_expired_q <= 1'b1;
                end else begin
                    timer_cnt_q <= timer_cnt_q + 32'h1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic safe_batt;
    logic safe_temp;
    logic safe_pump;

    assign safe_batt = in_safe && cause_q == sscf_pkg::SSCF_CAUSE_BATT;
    assign safe_temp = in_safe && cause_q == sscf_pkg::SSCF_CAUSE_TEMP;
    assign safe_pump = in_safe && cause_q == sscf_pkg::SSCF_CAUSE_PUMP;

    property p_temp_batt;
        @(posedge core_clk) disable iff (reset)
        safe_temp && ev_batt && !return_active |=>
            in_safe && !thresh_fast_q && $stable(fault_count_q);
    endproperty
    a_temp_batt: assert property (p_temp_batt)
        else $error("supply dip in temperature SAFE mishandled");

    property p_pump_batt;
        @(posedge core_clk) disable iff (reset)
        safe_pump && ev_batt && !ev_temp && !return_active |=>
            in_safe && thresh_fast_q && $stable(fault_count_q);
    endproperty
    a_pump_batt: assert property (p_pump_batt)
        else $error("supply dip in pump SAFE mishandled");

    property p_batt_temp;
        @(posedge core_clk) disable iff (reset)
        safe_batt && ev_temp |=>
            fault_count_q == 3'($past(fault_count_q) + 3'h1) &&
            !thresh_fast_q;
    endproperty
    a_batt_temp: assert property (p_batt_temp)
        else $error("overheat in supply SAFE not counted");

    property p_batt_latch;
        @(posedge core_clk) disable iff (reset)
        safe_batt && (ev_temp || ev_pump) && fault_count_q == 3'h3 |=>
            mode_q == sscf_pkg::SSCF_LATCH ##1
            mode_q == sscf_pkg::SSCF_LATCH;
    endproperty
    a_batt_latch: assert property (p_batt_latch)
        else $error("fourth fault did not latch");

    property p_batt_pump;
        @(posedge core_clk) disable iff (reset)
        safe_batt && ev_pump && !ev_temp |=>
            fault_count_q == 3'($past(fault_count_q) + 3'h1) &&
            thresh_fast_q;
    endproperty
    a_batt_pump: assert property (p_batt_pump)
        else $error("pump fault in supply SAFE not counted");

    property p_pump_temp;
        @(posedge core_clk) disable iff (reset)
        safe_pump && ev_temp |=> !thresh_fast_q && $stable(fault_count_q);
    endproperty
    a_pump_temp: assert property (p_pump_temp)
        else $error("overheat in pump SAFE mishandled");

    property p_temp_pump;
        @(posedge core_clk) disable iff (reset)
        safe_temp && ev_pump && !return_active |=>
            in_safe && $stable(fault_count_q);
    endproperty
    a_temp_pump: assert property (p_temp_pump)
        else $error("pump fault in temperature SAFE counted");

    property p_restart;
        @(posedge core_clk) disable iff (reset)
        in_safe && return_active && !bump |=>
            timer_restart_q && timer_running_q && timer_cnt_q == 32'h0
            ##1 !timer_restart_q;
    endproperty
    a_restart: assert property (p_restart)
        else $error("refresh timer not restarted on return");

    property p_same_fault;
        @(posedge core_clk) disable iff (reset)
        in_safe && !return_active &&
        ((cause_q == sscf_pkg::SSCF_CAUSE_BATT && ev == 3'h1) ||
         (cause_q == sscf_pkg::SSCF_CAUSE_TEMP && ev == 3'h2) ||
         (cause_q == sscf_pkg::SSCF_CAUSE_PUMP && ev == 3'h4)) |=>
            in_safe && $stable(fault_count_q) && $stable(thresh_fast_q);
    endproperty
    a_same_fault: assert property (p_same_fault)
        else $error("repeat of causing fault changed state");

endmodule

// File: sscf_defs.svh
`ifndef SSCF_DEFS_SVH
`define SSCF_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSCF_CLK_KHZ        10000
`define SSCF_SLOW_MS        30000
`define SSCF_FAST_MS        100
`define SSCF_SLOW_CYCLES    (`SSCF_SLOW_MS * `SSCF_CLK_KHZ)
`define SSCF_FAST_CYCLES    (`SSCF_FAST_MS * `SSCF_CLK_KHZ)

// ----------------------------------------------------------------
// Fault vector bit positions and counter limits
// ----------------------------------------------------------------
`define SSCF_BIT_BATT       0
`define SSCF_BIT_TEMP       1
`define SSCF_BIT_PUMP       2
`define SSCF_LATCH_COUNT    3'h4
`define SSCF_COUNT_RESET    3'h0

`endif

// File: sscf_pkg.sv
package sscf_pkg;

    // Operating mode as seen by this block
    typedef enum logic [1:0] {
        SSCF_ACTIVE,
        SSCF_SAFE,
        SSCF_LATCH
    } sscf_mode_t;

    // Fault that caused the present SAFE entry
    typedef enum logic [1:0] {
        SSCF_CAUSE_BATT,
        SSCF_CAUSE_TEMP,
        SSCF_CAUSE_PUMP
    } sscf_cause_t;

endpackage

// File: sscf_fault_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Fault detector model
// ----------------------------------------------------------------
module sscf_fault_model (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [2:0] fire,
    output logic [2:0]      pins_q
);
    logic [2:0] hold_q;

    // Stretch each request to a level that outlasts the synchroniser
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pins_q <= 3'h0;
            hold_q <= 3'h0;
        end else if (fire != 3'h0) begin
            pins_q <= fire;
            hold_q <= 3'h5;
        end else if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
        end else begin
            pins_q <= 3'h0; // Released detector reads low, not stale
        end
    end
endmodule

// File: tb_sscf_top.sv
`timescale 1ns/10ps
`include "sscf_defs.svh"

module tb_sscf_top;
    // Short counts keep the run small; expectations follow these
    localparam int unsigned SLOW = 20;
    localparam int unsigned FAST = 5;
    logic                  core_clk;
    logic                  reset;
    logic                  safe_enter;
    logic                  return_active;
    sscf_pkg::sscf_cause_t safe_cause;
    logic [2:0]            entry_fault_count;
    logic [2:0]            fire;
    logic [2:0]            pins;
    sscf_pkg::sscf_mode_t  mode_q;
    sscf_pkg::sscf_cause_t cause_q;
    logic [2:0]            fault_count_q;
    logic                  thresh_fast_q;
    logic                  timer_restart_q;
    logic                  timer_running_q;
    logic                  refresh_expired_q;
    int                    fail_count;
    int                    n_tests;
    int                    cyc;
    logic [7:0]            lfsr;
    logic [2:0]            e_in;
    logic [7:0]            dut_st;

    // Packed {mode, count, fast}, padded to the compare width
    assign dut_st = {2'h0, mode_q, fault_count_q, thresh_fast_q};

    sscf_fault_model model_u (
        .core_clk (core_clk),
        .reset    (reset),
        .fire     (fire),
        .pins_q   (pins)
    );

    sscf_top #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST)) dut_u (
        .core_clk          (core_clk),
        .reset             (reset),
        .battery_supply_uv (pins[`SSCF_BIT_BATT]),
        .overtemp          (pins[`SSCF_BIT_TEMP]),
        .charge_pump_uv    (pins[`SSCF_BIT_PUMP]),
        .safe_enter        (safe_enter),
        .safe_cause        (safe_cause),
        .entry_fault_count (entry_fault_count),
        .return_active     (return_active),
        .mode_q            (mode_q),
        .cause_q           (cause_q),
        .fault_count_q     (fault_count_q),
        .thresh_fast_q     (thresh_fast_q),
        .timer_restart_q   (timer_restart_q),
        .timer_running_q   (timer_running_q),
        .refresh_expired_q (refresh_expired_q)
    );

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc >= 5000) begin
            fail_count = fail_count + 1;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Expected {mode, count, fast} after fault f in SAFE of cause c
    function automatic logic [5:0] exp_state(input int c, input int f,
                                             input logic [2:0] e);
        logic [2:0] n;
        logic       fast;
        logic [1:0] m;
        n = e;
        fast = (c == 2);
        m = sscf_pkg::SSCF_SAFE;
        if (c == 0 && f != 0) begin
            n = e + 3'h1; // Only a supply-caused SAFE counts again
            fast = (f == 2);
        end else if (c != f) begin
            fast = (c == 2 && f == 0);
        end
        if (n >= `SSCF_LATCH_COUNT)
            m = sscf_pkg::SSCF_LATCH;
        return {m, n, fast};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reset_dut();
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
    endtask

    // Enter SAFE, raise one fault, then latch out or return
    task automatic run_case(input int c, input int f, input logic [2:0] e);
        logic [5:0] x;
        int         lim;
        x = exp_state(c, f, e);
        @(posedge core_clk);
        safe_enter <= 1'b1;
        safe_cause <= sscf_pkg::sscf_cause_t'(c);
        entry_fault_count <= e;
        @(posedge core_clk);
        safe_enter <= 1'b0;
        @(negedge core_clk);
        check(dut_st, {2'h0, 2'h1, e, c == 2});
        @(posedge core_clk);
        fire <= 3'h1 << f;
        @(posedge core_clk);
        fire <= 3'h0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        check(dut_st, {2'h0, x});
        check({6'h0, cause_q}, 8'(c));
        if (x[5:4] == sscf_pkg::SSCF_LATCH) begin
            reset_dut();
        end else begin
            lim = x[0] ? FAST : SLOW;
            @(posedge core_clk);
            return_active <= 1'b1;
            @(posedge core_clk);
            return_active <= 1'b0;
            @(negedge core_clk);
            check({4'h0, mode_q, timer_restart_q, timer_running_q},
                  8'h3);
            repeat (lim) @(posedge core_clk);
            @(negedge core_clk);
            check({7'h0, refresh_expired_q}, 8'h1);
        end
        $display("case cause %0d fault %0d count %0d done", c, f, e);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        safe_enter = 1'b0;
        return_active = 1'b0;
        safe_cause = sscf_pkg::SSCF_CAUSE_BATT;
        entry_fault_count = 3'h0;
        fire = 3'h0;
        fail_count = 0;
        n_tests = 0;
        cyc = 0;
        lfsr = 8'h42;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        @(negedge core_clk);
        check(dut_st, 8'h0);
        // Pass 0 sits at the latch boundary, pass 1 is random
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 3; c++) begin
                for (int f = 0; f < 3; f++) begin
                    lfsr = lfsr_next(lfsr);
                    e_in = p == 0 ? 3'h3 : {1'b0, lfsr[1:0]};
                    run_case(c, f, e_in);
                end
            end
        end
        // Count survives a return, so clear it to a known zero first
        reset_dut();
        // A fault while ACTIVE is ignored by this block
        @(posedge core_clk);
        fire <= 3'h2;
        @(posedge core_clk);
        fire <= 3'h0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        check({3'h0, mode_q, fault_count_q}, 8'h0);
        $display("active fault test done");
        complete_run();
    end
endmodule
